// *** hdl/bsd_pkg.sv ***
// Package of constants and types for the bus socket address decoder
package bsd_pkg;
   // Bus widths
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int LANES = 4;
   // Transfer size encoding on the socket
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   // Decoder alignment setting
   localparam logic [1:0] ALIGN_BYTE = 2'h0;
   localparam logic [1:0] ALIGN_HALF = 2'h1;
   localparam logic [1:0] ALIGN_WORD = 2'h2;
   // Decoder modes
   localparam logic [1:0] MODE_DECODE = 2'h0;
   localparam logic [1:0] MODE_CHIPSEL = 2'h1;
   localparam logic [1:0] MODE_DMA = 2'h2;
   // Reset values of masks: match nothing until loaded
   localparam logic [31:0] MASK_RST = 32'h0000_0000;
   localparam logic [1:0] MODE_RST = 2'h0;
   localparam logic [1:0] ALIGN_RST = 2'h2;
   // Load sequencer states
   typedef enum logic [1:0] {
      LD_IDLE = 2'b01,
      LD_DONE = 2'b10
   } bsd_load_t;
endpackage

// *** hdl/bsd_selector.sv ***
// One address decoder: mask compare, lane qualification and mode outputs
module bsd_selector (
   input wire logic clk,
   input wire logic rstSync_n,
   input wire logic cfgLoad,
   input wire logic cfgLocked,
   input wire logic [31:0] cfgLowMask,
   input wire logic [31:0] cfgHighMask,
   input wire logic [1:0] cfgMode,
   input wire logic [1:0] cfgAlign,
   input wire logic busActive,
   input wire logic busWrite,
   input wire logic [31:0] busAddr,
   input wire logic [3:0] laneEnable,
   input wire logic dmaReqIn,
   input wire logic dmaAckIn,
   input wire logic earlyStopReqIn,
   input wire logic earlyStopAckIn,
   output logic [1:0] read_decode_strobe,
   output logic [1:0] write_decode_strobe,
   output logic [1:0] chipSelect,
   output logic dma_request_steer,
   output logic dma_acknowledge_steer,
   output logic early_stop_request,
   output logic early_stop_acknowledge
);
   logic [31:0] low_match_mask;
   logic [31:0] high_match_mask;
   logic [1:0] mode;
   logic [1:0] align;
   logic [31:0] next_low;
   logic [31:0] next_high;
   logic [1:0] next_mode;
   logic [1:0] next_align;
   logic hit;
   logic [1:0] pairHit;
   logic [1:0] laneSel;

   // ----------------------------------------------------
   // Mask storage
   // ----------------------------------------------------
   // Written only while unlocked, then frozen
   always_comb begin
      next_low = low_match_mask;
      next_high = high_match_mask;
      next_mode = mode;
      next_align = align;
      if (cfgLoad && !cfgLocked) begin
         next_low = cfgLowMask;
         next_high = cfgHighMask;
         next_mode = cfgMode;
         next_align = cfgAlign;
      end
   end

   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         low_match_mask <= bsd_pkg::MASK_RST;
         high_match_mask <= bsd_pkg::MASK_RST;
         mode <= bsd_pkg::MODE_RST;
         align <= bsd_pkg::ALIGN_RST;
      end else begin
         low_match_mask <= next_low;
         high_match_mask <= next_high;
         mode <= next_mode;
         align <= next_align;
      end
   end

   // ----------------------------------------------------
   // Address compare and lane qualification
   // ----------------------------------------------------
   // A bit matches if low mask allows zero or high mask allows one;
   // both set means don't care
   assign hit = busActive &&
      (&((low_match_mask & ~busAddr) |
         (high_match_mask & busAddr)));

   // Word setting uses both outputs as halves; half ORs lanes 3:2 onto
   // lanes 1:0 whatever A[1]; byte uses one of two lane pairs chosen by A[1]
   always_comb begin
      pairHit = 2'h0;
      laneSel = 2'h0;
      case (align)
         bsd_pkg::ALIGN_WORD: begin
            pairHit = {|laneEnable[3:2], |laneEnable[1:0]};
         end
         bsd_pkg::ALIGN_HALF: begin
            laneSel = laneEnable[3:2] | laneEnable[1:0];
            pairHit = laneSel;
         end
         default: begin
            laneSel = busAddr[1] ? laneEnable[3:2] : laneEnable[1:0];
            pairHit = laneSel;
         end
      endcase
   end

   // ----------------------------------------------------
   // Mode outputs, same cycle as address
   // ----------------------------------------------------
   always_comb begin
      read_decode_strobe = 2'h0;
      write_decode_strobe = 2'h0;
      chipSelect = 2'h0;
      dma_request_steer = 1'b0;
      dma_acknowledge_steer = 1'b0;
      early_stop_request = 1'b0;
      early_stop_acknowledge = 1'b0;
      case (mode)
         bsd_pkg::MODE_DECODE: begin
            if (hit && !busWrite)
               read_decode_strobe = pairHit;
            if (hit && busWrite)
               write_decode_strobe = pairHit;
         end
         bsd_pkg::MODE_CHIPSEL: begin
            if (hit)
               chipSelect = pairHit;
            if (hit && !busWrite)
               read_decode_strobe = pairHit;
         end
         bsd_pkg::MODE_DMA: begin
            dma_request_steer = dmaReqIn;
            dma_acknowledge_steer = dmaAckIn;
            early_stop_request = earlyStopReqIn;
            early_stop_acknowledge = earlyStopAckIn;
            if (hit && !busWrite)
               read_decode_strobe = pairHit;
            if (hit && busWrite)
               write_decode_strobe = pairHit;
         end
         default: begin
         end
      endcase
   end

   // ----------------------------------------------------
   // Checks
   // ----------------------------------------------------
   a_idle_quiet: assert property (@(posedge clk) disable iff (!rstSync_n)
      !busActive |-> (read_decode_strobe == 2'h0 &&
         write_decode_strobe == 2'h0 && chipSelect == 2'h0))
      else $error("decoder output while bus idle");
   a_write_no_read: assert property (@(posedge clk)
      disable iff (!rstSync_n)
      busWrite |-> read_decode_strobe == 2'h0)
      else $error("read strobe on write");
   a_masks_frozen: assert property (@(posedge clk)
      disable iff (!rstSync_n)
      cfgLocked |=> $stable(low_match_mask) && $stable(high_match_mask))
      else $error("mask changed after lock");
   a_cs_both_dirs: assert property (@(posedge clk)
      disable iff (!rstSync_n)
      (mode == bsd_pkg::MODE_CHIPSEL && hit && busWrite)
      |-> chipSelect == pairHit)
      else $error("chip select missed a write");
endmodule

// *** hdl/bsd_socket.sv ***
// Bus socket top: data steering, read OR, and the decoder array
module bsd_socket #(
   parameter int NUM_SEL = 32,
   parameter int NUM_FUNC = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   // Master side
   input wire logic mstActive,
   input wire logic mstWrite,
   input wire logic [1:0] mstSize,
   input wire logic [31:0] mstAddr,
   input wire logic [31:0] mstWriteData,
   output logic [31:0] mstReadData,
   // Configuration load during initialisation
   input wire logic cfgLoad,
   input wire logic [$clog2(NUM_SEL)-1:0] cfgIndex,
   input wire logic [31:0] cfgLowMask,
   input wire logic [31:0] cfgHighMask,
   input wire logic [1:0] cfgMode,
   input wire logic [1:0] cfgAlign,
   input wire logic cfgDone,
   output logic cfgLocked,
   // Logic matrix side
   output logic sockActive,
   output logic sockWrite,
   output logic [31:0] sockAddr,
   output logic [31:0] sockWriteData,
   output logic [3:0] sockLaneEnable,
   input wire logic [NUM_FUNC*32-1:0] funcReadData,
   output logic [NUM_SEL*2-1:0] read_decode_strobe,
   output logic [NUM_SEL*2-1:0] write_decode_strobe,
   output logic [NUM_SEL*2-1:0] chipSelect,
   // DMA steering per decoder
   input wire logic [NUM_SEL-1:0] funcDmaReq,
   input wire logic [NUM_SEL-1:0] chanDmaAck,
   input wire logic [NUM_SEL-1:0] funcEarlyStopReq,
   input wire logic [NUM_SEL-1:0] chanEarlyStopAck,
   output logic [NUM_SEL-1:0] dma_request_steer,
   output logic [NUM_SEL-1:0] dma_acknowledge_steer,
   output logic [NUM_SEL-1:0] early_stop_request,
   output logic [NUM_SEL-1:0] early_stop_acknowledge
);
   // ----------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------
   if (NUM_SEL < 2 || NUM_FUNC < 1) begin : g_bad_param
      $error("bsd_socket needs NUM_SEL >= 2 and NUM_FUNC >= 1");
   end

   logic rstMeta_n;
   logic rstSync_n;
   bsd_pkg::bsd_load_t loadState;
   bsd_pkg::bsd_load_t next_loadState;
   logic [3:0] laneEnable;
   logic [31:0] wrSteered;
   logic [31:0] rdOr;
   logic [NUM_SEL-1:0] loadHit;

   // ----------------------------------------------------
   // Reset synchroniser
   // ----------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_n <= 1'b0;
         rstSync_n <= 1'b0;
      end else begin
         rstMeta_n <= 1'b1;
         rstSync_n <= rstMeta_n;
      end
   end

   // ----------------------------------------------------
   // Load lock: masks frozen once initialisation ends
   // ----------------------------------------------------
   always_comb begin
      next_loadState = loadState;
      case (loadState)
         bsd_pkg::LD_IDLE: begin
            if (cfgDone)
               next_loadState = bsd_pkg::LD_DONE;
         end
         bsd_pkg::LD_DONE: begin
            next_loadState = bsd_pkg::LD_DONE;
         end
         default: begin
            next_loadState = bsd_pkg::LD_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n)
         loadState <= bsd_pkg::LD_IDLE;
      else
         loadState <= next_loadState;
   end

   assign cfgLocked = (loadState == bsd_pkg::LD_DONE);

   // ----------------------------------------------------
   // Lane enables and write data replication
   // ----------------------------------------------------
   // Lane from size and low address bits; fixed lanes, no shifting
   function automatic logic [3:0] lanes_of(input logic [1:0] size,
                                           input logic [1:0] a);
      logic [3:0] l;
      l = 4'h0;
      case (size)
         bsd_pkg::SIZE_WORD: l = 4'hF;
         bsd_pkg::SIZE_HALF: l = a[1] ? 4'hC : 4'h3;
         bsd_pkg::SIZE_BYTE: l = 4'(4'h1 << a);
         default: l = 4'h0;
      endcase
      return l;
   endfunction

   always_comb begin
      laneEnable = lanes_of(mstSize, mstAddr[1:0]);
      case (mstSize)
         bsd_pkg::SIZE_HALF: begin
            // Upper or lower half copied to both halves
            wrSteered = mstAddr[1] ?
               {2{mstWriteData[31:16]}} :
               {2{mstWriteData[15:0]}};
         end
         bsd_pkg::SIZE_BYTE: begin
            case (mstAddr[1:0])
               2'h0: wrSteered = {4{mstWriteData[7:0]}};
               2'h1: wrSteered = {4{mstWriteData[15:8]}};
               2'h2: wrSteered = {4{mstWriteData[23:16]}};
               default: wrSteered = {4{mstWriteData[31:24]}};
            endcase
         end
         default: wrSteered = mstWriteData;
      endcase
   end

   // Address and data shown to the matrix as driven this cycle
   assign sockActive = mstActive;
   assign sockWrite = mstWrite;
   assign sockAddr = mstAddr;
   assign sockWriteData = wrSteered;
   assign sockLaneEnable = mstActive ? laneEnable : 4'h0;

   // ----------------------------------------------------
   // Read return OR; unselected functions must send zeros
   // ----------------------------------------------------
   always_comb begin
      rdOr = 32'h0000_0000;
      for (int f = 0; f < NUM_FUNC; f++)
         rdOr = rdOr | funcReadData[f*32 +: 32];
   end

   // Registered so the master samples on the next rising edge
   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n)
         mstReadData <= 32'h0000_0000;
      else
         mstReadData <= (mstActive && !mstWrite) ? rdOr : 32'h0000_0000;
   end

   // ----------------------------------------------------
   // Decoder array
   // ----------------------------------------------------
   // Range size follows from which mask bits are don't care
   for (genvar s = 0; s < NUM_SEL; s++) begin : g_sel
      assign loadHit[s] = cfgLoad &&
         (cfgIndex == ($clog2(NUM_SEL))'(s));
      bsd_selector u_sel (
         .clk(clk),
         .rstSync_n(rstSync_n),
         .cfgLoad(loadHit[s]),
         .cfgLocked(cfgLocked),
         .cfgLowMask(cfgLowMask),
         .cfgHighMask(cfgHighMask),
         .cfgMode(cfgMode),
         .cfgAlign(cfgAlign),
         .busActive(mstActive),
         .busWrite(mstWrite),
         .busAddr(mstAddr),
         .laneEnable(laneEnable),
         .dmaReqIn(funcDmaReq[s]),
         .dmaAckIn(chanDmaAck[s]),
         .earlyStopReqIn(funcEarlyStopReq[s]),
         .earlyStopAckIn(chanEarlyStopAck[s]),
         .read_decode_strobe(read_decode_strobe[2*s +: 2]),
         .write_decode_strobe(write_decode_strobe[2*s +: 2]),
         .chipSelect(chipSelect[2*s +: 2]),
         .dma_request_steer(dma_request_steer[s]),
         .dma_acknowledge_steer(dma_acknowledge_steer[s]),
         .early_stop_request(early_stop_request[s]),
         .early_stop_acknowledge(early_stop_acknowledge[s])
      );
   end

   // ----------------------------------------------------
   // Checks
   // ----------------------------------------------------
   a_half_dup: assert property (@(posedge clk) disable iff (!rstSync_n)
      (mstActive && mstSize == bsd_pkg::SIZE_HALF)
      |-> sockWriteData[31:16] == sockWriteData[15:0])
      else $error("half-word not duplicated");
   a_byte_rep: assert property (@(posedge clk) disable iff (!rstSync_n)
      (mstActive && mstSize == bsd_pkg::SIZE_BYTE)
      |-> (sockWriteData == {4{sockWriteData[7:0]}} &&
           $onehot(sockLaneEnable)))
      else $error("byte not replicated");
   a_read_or: assert property (@(posedge clk) disable iff (!rstSync_n)
      (mstActive && !mstWrite) |=> mstReadData == $past(rdOr))
      else $error("read return mismatch");
   a_lock_sticks: assert property (@(posedge clk)
      disable iff (!rstSync_n)
      cfgDone |=> cfgLocked [*3])
      else $error("lock dropped");
   a_word_lanes: assert property (@(posedge clk) disable iff (!rstSync_n)
      (mstActive && mstSize == bsd_pkg::SIZE_WORD)
      |-> sockLaneEnable == 4'hF)
      else $error("word lanes wrong");

   // ----------------------------------------------------
   // Socket-level checks on steering and the read return
   // ----------------------------------------------------
   // Idle cycles must show no lanes, or a function could
   // latch stale data left on the write bus
   a_idle_lanes: assert property (@(posedge clk)
      disable iff (!rstSync_n)
      !mstActive |-> sockLaneEnable == 4'h0)
      else $error("byte lanes active while bus idle");
   a_idle_strobes: assert property (@(posedge clk)
      disable iff (!rstSync_n)
      !mstActive |-> (read_decode_strobe == '0 &&
         write_decode_strobe == '0 && chipSelect == '0))
      else $error("decode output while bus idle");
   // Return path falls to zero after anything but a read
   a_read_quiet: assert property (@(posedge clk)
      disable iff (!rstSync_n)
      !(mstActive && !mstWrite) |=> mstReadData == 32'h0000_0000)
      else $error("read return not cleared");
   // Word data passes through untouched
   a_word_data: assert property (@(posedge clk)
      disable iff (!rstSync_n)
      (mstActive && mstSize == bsd_pkg::SIZE_WORD)
      |-> sockWriteData == mstWriteData)
      else $error("word data altered");
   // The duplicated half must come from the addressed half
   a_half_source: assert property (@(posedge clk)
      disable iff (!rstSync_n)
      (mstActive && mstSize == bsd_pkg::SIZE_HALF)
      |-> sockWriteData[15:0] ==
         (mstAddr[1] ? mstWriteData[31:16] : mstWriteData[15:0]))
      else $error("half-word taken from wrong half");
   a_half_lanes: assert property (@(posedge clk)
      disable iff (!rstSync_n)
      (mstActive && mstSize == bsd_pkg::SIZE_HALF)
      |-> sockLaneEnable == (mstAddr[1] ? 4'hC : 4'h3))
      else $error("half-word lanes wrong");
   // The replicated byte must come from the addressed lane
   a_byte_source: assert property (@(posedge clk)
      disable iff (!rstSync_n)
      (mstActive && mstSize == bsd_pkg::SIZE_BYTE)
      |-> (sockWriteData[7:0] == mstWriteData[8*mstAddr[1:0] +: 8] &&
           sockLaneEnable[mstAddr[1:0]]))
      else $error("byte taken from wrong lane");
   // An undefined size must enable no lane at all
   a_size_none: assert property (@(posedge clk)
      disable iff (!rstSync_n)
      (mstActive && mstSize == 2'h3) |-> sockLaneEnable == 4'h0)
      else $error("lanes enabled for undefined size");
   // Lock holds until reset, so masks never reopen
   a_lock_holds: assert property (@(posedge clk)
      disable iff (!rstSync_n)
      cfgLocked |=> cfgLocked)
      else $error("lock released without reset");
   // Only the indexed decoder may take a load
   a_load_single: assert property (@(posedge clk)
      disable iff (!rstSync_n)
      $onehot0(loadHit))
      else $error("several decoders loaded at once");
endmodule

// *** testbench/bsd_func_model.sv ***
// Partner model: two user functions in the logic matrix returning read data
module bsd_func_model #(
   parameter logic [31:0] VALUE0 = 32'hA5C3_1E77,
   parameter logic [31:0] VALUE1 = 32'h5B2D_90F4
) (
   input wire logic [7:0] readStrobe,
   input wire logic [3:0] laneEnable,
   output logic [63:0] funcReadData
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] laneMask;

   // --------------------------------------------------------------
   // Read return
   // --------------------------------------------------------------
   // Function 0 sits on decoder 0, function 1 on decoder 1
   always_comb begin
      laneMask = {{8{laneEnable[3]}}, {8{laneEnable[2]}},
                  {8{laneEnable[1]}}, {8{laneEnable[0]}}};
      funcReadData = 64'h0;
      if (|readStrobe[1:0]) begin
         funcReadData[31:0] = VALUE0 & laneMask;
      end
      if (|readStrobe[3:2]) begin
         funcReadData[63:32] = VALUE1 & laneMask;
      end
   end
endmodule

// *** testbench/bus_socket_address_decoder_tb.sv ***
// Self-checking bench for the bus socket address decoder
module bus_socket_address_decoder_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, act, wr, cfgLoad, cfgDone, cfgLocked, sAct, sWr;
   logic [1:0] size, cMode, cAlign, cIdx;
   logic [31:0] addr, wd, rd, cLo, cHi, sAddr, sWd, lfsr, expRead;
   logic [3:0] sLane, dReq, dAck, eReq, eAck, oReq, oAck, oEr, oEa;
   logic [7:0] rdS, wrS, csS;
   logic [63:0] fRd;
   logic [31:0] lo [4];
   logic [31:0] hi [4];
   logic [1:0] md [4];
   logic [1:0] al [4];
   logic locked;
   int failCount, samplesChecked;
   // Read values of the two partner functions, shared with the model
   localparam logic [31:0] FUNC_V0 = 32'hA5C3_1E77;
   localparam logic [31:0] FUNC_V1 = 32'h5B2D_90F4;

   bsd_socket #(.NUM_SEL(4), .NUM_FUNC(2)) u_dut (.clk(clk), .rst_n(rst_n),
      .mstActive(act), .mstWrite(wr), .mstSize(size), .mstAddr(addr),
      .mstWriteData(wd), .mstReadData(rd), .cfgLoad(cfgLoad),
      .cfgIndex(cIdx), .cfgLowMask(cLo), .cfgHighMask(cHi), .cfgMode(cMode),
      .cfgAlign(cAlign), .cfgDone(cfgDone), .cfgLocked(cfgLocked),
      .sockActive(sAct), .sockWrite(sWr), .sockAddr(sAddr),
      .sockWriteData(sWd), .sockLaneEnable(sLane), .funcReadData(fRd),
      .read_decode_strobe(rdS), .write_decode_strobe(wrS),
      .chipSelect(csS), .funcDmaReq(dReq), .chanDmaAck(dAck),
      .funcEarlyStopReq(eReq), .chanEarlyStopAck(eAck),
      .dma_request_steer(oReq), .dma_acknowledge_steer(oAck),
      .early_stop_request(oEr), .early_stop_acknowledge(oEa));

   bsd_func_model #(.VALUE0(FUNC_V0), .VALUE1(FUNC_V1)) u_func (
      .readStrobe(rdS), .laneEnable(sLane), .funcReadData(fRd));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04C1_1DB7 : 32'h0);
      return lfsr;
   endfunction

   function automatic logic [3:0] lanesOf(logic [1:0] s, logic [1:0] a);
      case (s)
         bsd_pkg::SIZE_BYTE: return 4'h1 << a;
         bsd_pkg::SIZE_HALF: return a[1] ? 4'hC : 4'h3;
         bsd_pkg::SIZE_WORD: return 4'hF;
         default: return 4'h0;
      endcase
   endfunction

   // Strobe pair per alignment setting
   function automatic logic [1:0] pairOf(logic [1:0] g, logic [3:0] l,
                                         logic a1);
      case (g)
         bsd_pkg::ALIGN_WORD: return {|l[3:2], |l[1:0]};
         bsd_pkg::ALIGN_HALF: return {l[1] | l[3], l[0] | l[2]};
         default: return a1 ? l[3:2] : l[1:0];
      endcase
   endfunction

   task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                      input string what);
      samplesChecked++;
      if (got !== exp) begin
         failCount++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic giveVerdict();
      $display("checks %0d mismatches %0d", samplesChecked, failCount);
      if (failCount == 0 && samplesChecked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Region: base with the low dcBits as don't care
   task automatic load(input logic [1:0] i, input logic [31:0] base,
                       input int dcBits, input logic [1:0] m,
                       input logic [1:0] g);
      logic [31:0] dc;
      dc = (32'h1 << dcBits) - 32'h1;
      @(posedge clk);
      #1;
      cfgLoad = 1'b1;
      cIdx = i;
      cLo = ~base | dc;
      cHi = base | dc;
      cMode = m;
      cAlign = g;
      if (!locked) begin
         lo[i] = cLo;
         hi[i] = cHi;
         md[i] = m;
         al[i] = g;
      end
   endtask

   // Random traffic, mostly aimed at the configured regions
   task automatic run(input int n);
      logic [31:0] r, lm, bases [4];
      logic [1:0] p;
      logic [7:0] eR, eW, eC;
      logic [3:0] l, dm;
      logic m;
      bases = '{32'h4000_0000, 32'h8000_0100, 32'hC000_0000, 32'h0};
      for (int k = 0; k < n; k++) begin
         @(posedge clk);
         #1;
         chk(rd, expRead, "read return");
         r = rnd();
         act = r[31] | r[30];
         wr = r[29];
         size = r[28:27];
         addr = (r[1:0] == 2'h3) ? rnd() : bases[r[1:0]] | {28'h0, r[7:4]};
         if (size == bsd_pkg::SIZE_WORD) addr[1:0] = 2'h0;
         if (size == bsd_pkg::SIZE_HALF) addr[0] = 1'b0;
         wd = rnd();
         r = rnd();
         {dReq, dAck, eReq, eAck} = r[15:0];
         #6;
         l = act ? lanesOf(size, addr[1:0]) : 4'h0;
         for (int s = 0; s < 4; s++) begin
            m = act && (&((~addr & lo[s]) | (addr & hi[s])));
            p = m ? pairOf(al[s], l, addr[1]) : 2'h0;
            eR[2*s+:2] = wr ? 2'h0 : p;
            eW[2*s+:2] = (wr && md[s] != bsd_pkg::MODE_CHIPSEL) ? p : 2'h0;
            eC[2*s+:2] = (md[s] == bsd_pkg::MODE_CHIPSEL) ? p : 2'h0;
            dm[s] = md[s] == bsd_pkg::MODE_DMA;
         end
         chk({sAct, sWr, sAddr}, {act, wr, addr}, "address port");
         chk(sLane, l, "byte lanes");
         chk(rdS, eR, "read strobes");
         chk(wrS, eW, "write strobes");
         chk(csS, eC, "chip selects");
         chk({oReq, oAck, oEr, oEa}, {dReq & dm, dAck & dm, eReq & dm,
             eAck & dm}, "dma steering");
         if (size == bsd_pkg::SIZE_BYTE) begin
            chk(sWd, {4{wd[8*addr[1:0]+:8]}}, "byte data");
         end else if (size == bsd_pkg::SIZE_HALF) begin
            chk(sWd, {2{wd[16*addr[1]+:16]}}, "half data");
         end else if (size == bsd_pkg::SIZE_WORD) begin
            chk(sWd, wd, "word data");
         end
         // Expected return from our own strobes, not the model's output
         lm = {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
         expRead = ({32{|eR[1:0]}} & FUNC_V0 & lm) |
            ({32{|eR[3:2]}} & FUNC_V1 & lm);
      end
      // Check the last read, then idle so later loads see no traffic
      @(posedge clk);
      #1;
      chk(rd, expRead, "read return");
      act = 1'b0;
      expRead = 32'h0;
   endtask

   // ---------------------------------------------------------------
   // Clock and watchdog
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      #100us;
      failCount++;
      giveVerdict();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      {rst_n, act, wr, cfgLoad, cfgDone, locked} = '0;
      {size, cMode, cAlign, cIdx, addr, wd, cLo, cHi} = '0;
      {dReq, dAck, eReq, eAck, expRead} = '0;
      lfsr = 32'hF099_C9E0;
      for (int s = 0; s < 4; s++) begin
         lo[s] = bsd_pkg::MASK_RST;
         hi[s] = bsd_pkg::MASK_RST;
         md[s] = bsd_pkg::MODE_RST;
         al[s] = bsd_pkg::ALIGN_RST;
      end
      repeat (6) @(posedge clk);
      #1;
      rst_n = 1'b1;
      chk({rd, cfgLocked, rdS, wrS, csS}, '0, "reset state");
      run(20);
      repeat (3) @(posedge clk);
      // Back-to-back loads, first one overwritten by the second
      load(2'h0, 32'h1234_0000, 0, bsd_pkg::MODE_CHIPSEL,
           bsd_pkg::ALIGN_BYTE);
      load(2'h0, 32'h4000_0000, 4, bsd_pkg::MODE_DECODE,
           bsd_pkg::ALIGN_WORD);
      load(2'h1, 32'h8000_0100, 2, bsd_pkg::MODE_CHIPSEL,
           bsd_pkg::ALIGN_BYTE);
      load(2'h2, 32'h8000_0000, 31, bsd_pkg::MODE_DMA,
           bsd_pkg::ALIGN_HALF);
      @(posedge clk);
      #1;
      cfgLoad = 1'b0;
      run(400);
      cfgDone = 1'b1;
      locked = 1'b1;
      @(posedge clk);
      #1;
      cfgDone = 1'b0;
      @(posedge clk);
      #1;
      chk(cfgLocked, 1'b1, "locked");
      // Loads after lock must be ignored
      load(2'h3, 32'h0, 32, bsd_pkg::MODE_CHIPSEL,
           bsd_pkg::ALIGN_WORD);
      load(2'h0, 32'h0, 32, bsd_pkg::MODE_DMA, bsd_pkg::ALIGN_BYTE);
      @(posedge clk);
      #1;
      cfgLoad = 1'b0;
      run(400);
      giveVerdict();
   end
endmodule
